//--- hw/plsc_top.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Link-side control of a three-port cable physical layer
module plsc_top #(
   parameter int LINK_CLK_HZ = plsc_pkg::LINK_CLK_HZ,
   parameter int LINKON_HZ   = plsc_pkg::LINKON_HZ
) (
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [plsc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // Pins
   input  wire logic                          linkPowerSense,
   input  wire logic                          linkRequest,
   input  wire logic [plsc_pkg::PC_W-1:0]     powerClassInputs,
   input  wire logic                          powerDownInput,
   input  wire logic                          resetPin_n,
   input  wire logic                          factoryTestSel1,
   input  wire logic                          factoryTestSel2,
   input  wire logic                          managerCapLinkonIn,
   output logic                               managerCapLinkonOut,
   output logic                               managerCapLinkonOe,
   output logic                               cableInactiveFlag,
   output logic                               linkSideClock,
   // Core side
   input  wire logic [plsc_pkg::NPORTS-1:0]   portActive,
   input  wire logic                          linkOnMsg,
   output logic                               linkIfEnable,
   output logic                               linkReqStrobe,
   output logic      [plsc_pkg::NPORTS-1:0]   busResetReq,
   output logic      [0:plsc_pkg::SELFID_W-1] selfIdWord
);

   localparam int NP    = plsc_pkg::NPORTS;
   localparam int PCW   = plsc_pkg::PC_W;
   localparam int SYNC_W = 10 + PCW;
   localparam int RQW   = plsc_pkg::REQCNT_W;
   localparam int AW    = plsc_pkg::NCO_ACC_W;
   localparam longint ACC_SPAN = 64'h1_0000_0000;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(plsc_pkg::SYNC_RESET);
   localparam logic [AW-1:0] LINK_STEP =
      AW'((longint'(LINK_CLK_HZ) * ACC_SPAN) / longint'(plsc_pkg::SYS_CLK_HZ));
   localparam logic [AW-1:0] LINKON_STEP =
      AW'((longint'(LINKON_HZ) * ACC_SPAN) / longint'(plsc_pkg::SYS_CLK_HZ));

   typedef struct packed {
      logic [SYNC_W-1:0]   s1;
      logic [SYNC_W-1:0]   s2;
      logic [31:0]         ctrl;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
      logic                lreqPrev;
      logic                linkReq;
      logic [RQW-1:0]      reqCount;
      logic                linkOn;
      logic                mgrOe;
      logic [NP-1:0]       busReset;
      logic                cableInactive;
      logic                linkIf;
      logic [0:31]         selfId;
      logic [PCW-1:0]      pcStrap;
      logic                mgrStrap;
   } plsc_top_type;

   plsc_top_type st_ff;
   plsc_top_type nxt_st;

   // Synchronised pin view; first stage is read only by the second
   logic            lpsS;
   logic            lreqS;
   logic [PCW-1:0]  pcS;
   logic            pdS;
   logic            rstPinS_n;
   logic            test1S;
   logic            test2S;
   logic            mgrS;
   logic [NP-1:0]   portS;
   logic            lpsActive;
   logic            linkOnWave;
   logic            linkClkWave;

   assign {mgrS, portS, test2S, test1S, rstPinS_n, pdS, pcS, lreqS, lpsS} = st_ff.s2;

   // Sense qualifier is stopped in power-down and by the reset pin
   plsc_lps_detect u_lps (
      .sys_clk (sys_clk),
      .reset   (reset),
      .enable  (!pdS && rstPinS_n),
      .senseIn (lpsS),
      .active  (lpsActive)
   );

   // Link clock keeps running under the reset pin, stops in power-down
   plsc_nco #(.ACC_W(AW), .STEP(LINK_STEP)) u_linkclk (
      .sys_clk (sys_clk),
      .reset   (reset),
      .enable  (!pdS),
      .wave    (linkClkWave)
   );

   // Link-on tone generator
   plsc_nco #(.ACC_W(AW), .STEP(LINKON_STEP)) u_linkon (
      .sys_clk (sys_clk),
      .reset   (reset),
      .enable  (st_ff.linkOn),
      .wave    (linkOnWave)
   );

   // Next state of the whole block
   always_comb begin
      logic            pinReset;
      logic            setupPh;
      logic            accessPh;
      logic            swReset;
      logic [31:0]     rd;
      logic            hit;
      pinReset = !rstPinS_n;
      setupPh  = psel && !penable;
      accessPh = psel && penable && st_ff.pready;
      swReset  = st_ff.ctrl[plsc_pkg::CTRL_SWRST_BIT];
      rd       = '0;
      hit      = 1'b1;
      nxt_st   = st_ff;

      nxt_st.s1 = {managerCapLinkonIn, portActive, factoryTestSel2, factoryTestSel1,
                   resetPin_n, powerDownInput, powerClassInputs, linkRequest,
                   linkPowerSense};
      nxt_st.s2 = st_ff.s1;

      // Monitor runs regardless of power-down
      nxt_st.cableInactive = ~|portS;

      // Link interface only with sensed link power and no power-down
      nxt_st.linkIf = lpsActive && !pdS && !pinReset &&
                      !st_ff.ctrl[plsc_pkg::CTRL_LINKOFF_BIT];

      // Bus reset on every port seen active
      if ((pinReset || swReset) && !pdS) begin
         nxt_st.busReset = portS;
      end else begin
         nxt_st.busReset = '0;
      end

      // Request edges taken only while the link side is enabled
      nxt_st.lreqPrev = lreqS;
      nxt_st.linkReq  = lreqS && !st_ff.lreqPrev && st_ff.linkIf;
      if (pinReset) begin
         nxt_st.reqCount = '0;
      end else if (st_ff.linkReq) begin
         nxt_st.reqCount = st_ff.reqCount + 1'b1;
      end

      // Straps follow the pins while running, manager strap reads 0 while the pin is driven; frozen in power-down
      if (!pdS && !pinReset) begin
         nxt_st.pcStrap  = pcS;
         nxt_st.mgrStrap = mgrS && !st_ff.mgrOe;
      end
      nxt_st.selfId = '0;
      for (int i = 0; i < PCW; i++) begin
         nxt_st.selfId[plsc_pkg::PC_BIT_POS + i] = st_ff.pcStrap[PCW-1-i];
      end

      // Link-on: message sets, link power, power-down or reset clears; set wins only over link power
      if (pinReset || pdS || lpsActive) begin
         nxt_st.linkOn = 1'b0;
      end
      if (linkOnMsg && !pdS && !pinReset) begin
         nxt_st.linkOn = 1'b1;
      end
      nxt_st.mgrOe = st_ff.linkOn;

      // Software reset bit is a one-cycle request
      nxt_st.ctrl[plsc_pkg::CTRL_SWRST_BIT] = 1'b0;

      // Read mux
      unique case (paddr)
         plsc_pkg::CTRL_OFS: begin
            rd = st_ff.ctrl;
         end
         plsc_pkg::STATUS_OFS: begin
            rd[plsc_pkg::ST_LPS_BIT]    = lpsActive;
            rd[plsc_pkg::ST_LINKIF_BIT] = st_ff.linkIf;
            rd[plsc_pkg::ST_PD_BIT]     = pdS;
            rd[plsc_pkg::ST_CNA_BIT]    = st_ff.cableInactive;
            rd[plsc_pkg::ST_LINKON_BIT] = st_ff.linkOn;
            rd[plsc_pkg::ST_TESTOK_BIT] = test1S && test2S;
            rd[plsc_pkg::ST_RSTPIN_BIT] = pinReset;
            rd[plsc_pkg::ST_PORT_POS +: NP] = portS;
         end
         plsc_pkg::STRAP_OFS: begin
            rd[plsc_pkg::STRAP_PC_POS +: PCW] = st_ff.pcStrap;
            rd[plsc_pkg::STRAP_MGR_BIT]       = st_ff.mgrStrap;
         end
         plsc_pkg::REQCNT_OFS: begin
            rd[RQW-1:0] = st_ff.reqCount;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      // APB: no wait states, answer registered in the setup cycle
      if (accessPh) begin
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         nxt_st.prdata  = '0;
         if (pwrite && paddr == plsc_pkg::CTRL_OFS) begin
            nxt_st.ctrl = pwdata & plsc_pkg::CTRL_WMASK;
         end
      end else if (setupPh) begin
         nxt_st.pready  = 1'b1;
         nxt_st.pslverr = !hit;
         nxt_st.prdata  = (pwrite || !hit) ? 32'h0000_0000 : rd;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_ff      <= '0;
         st_ff.ctrl <= plsc_pkg::CTRL_RESET;
         // Idle pin levels, so no false reset-pin pulse follows reset
         st_ff.s1   <= SYNC_IDLE;
         st_ff.s2   <= SYNC_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign prdata              = st_ff.prdata;
   assign pready              = st_ff.pready;
   assign pslverr             = st_ff.pslverr;
   assign cableInactiveFlag   = st_ff.cableInactive;
   assign linkIfEnable        = st_ff.linkIf;
   assign linkReqStrobe       = st_ff.linkReq;
   assign busResetReq         = st_ff.busReset;
   assign selfIdWord          = st_ff.selfId;
   assign managerCapLinkonOe  = st_ff.mgrOe;
   assign managerCapLinkonOut = linkOnWave;
   assign linkSideClock       = linkClkWave;

endmodule
`default_nettype wire

//--- hw/plsc_pkg.sv
package plsc_pkg;

   // Clock and timing
   localparam int SYS_CLK_HZ  = 50_000_000;
   localparam int LPS_MIN_HZ  = 220_000;
   localparam int LPS_MAX_HZ  = 5_500_000;
   // Shortest legal period rounds up, longest rounds down
   localparam int LPS_MIN_PERIOD_CYC = (SYS_CLK_HZ + LPS_MAX_HZ - 1) / LPS_MAX_HZ;
   localparam int LPS_MAX_PERIOD_CYC = SYS_CLK_HZ / LPS_MIN_HZ;
   localparam int LPS_CNT_W   = 8;
   localparam int LINK_CLK_HZ = 49_152_000;
   localparam int LINKON_HZ   = 6_114_000;
   localparam int NCO_ACC_W   = 32;

   // Ports and Self-ID layout (bit 0 is the first bit sent)
   localparam int NPORTS      = 3;
   localparam int SELFID_W    = 32;
   localparam int PC_BIT_POS  = 21;
   localparam int PC_W        = 3;
   // Synchroniser reset image: reset pin and test selects idle high
   localparam logic [12:0] SYNC_RESET = 13'h01c0;

   // Register map, byte addresses
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  STATUS_OFS  = 8'h04;
   localparam logic [7:0]  STRAP_OFS   = 8'h08;
   localparam logic [7:0]  REQCNT_OFS  = 8'h0c;
   localparam int          REQCNT_W    = 16;

   // Control fields
   localparam int          CTRL_SWRST_BIT   = 0;
   localparam int          CTRL_LINKOFF_BIT = 1;
   localparam logic [31:0] CTRL_WMASK       = 32'h0000_0003;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

   // Status fields
   localparam int ST_LPS_BIT    = 0;
   localparam int ST_LINKIF_BIT = 1;
   localparam int ST_PD_BIT     = 2;
   localparam int ST_CNA_BIT    = 3;
   localparam int ST_LINKON_BIT = 4;
   localparam int ST_TESTOK_BIT = 5;
   localparam int ST_RSTPIN_BIT = 6;
   localparam int ST_PORT_POS   = 8;

   // Strap fields
   localparam int STRAP_PC_POS  = 0;
   localparam int STRAP_MGR_BIT = 4;

endpackage

//--- hw/plsc_nco.sv
`timescale 1ns/1ps
`default_nettype none
// Square wave from a phase accumulator, held low while disabled
module plsc_nco #(
   parameter int                ACC_W = plsc_pkg::NCO_ACC_W,
   parameter logic [ACC_W-1:0]  STEP  = '0
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic enable,
   output logic      wave
);

   typedef struct packed {
      logic [ACC_W-1:0] acc;
   } plsc_nco_type;

   plsc_nco_type st_ff;
   plsc_nco_type nxt_st;

   // Accumulate; restart from zero so each burst begins low
   always_comb begin
      nxt_st = st_ff;
      if (enable) begin
         nxt_st.acc = st_ff.acc + STEP;
      end else begin
         nxt_st.acc = '0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wave = st_ff.acc[ACC_W-1];

endmodule
`default_nettype wire

//--- hw/plsc_lps_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Link power sense qualifier: pulse-rate window or static level
module plsc_lps_detect #(
   parameter int CNT_W = plsc_pkg::LPS_CNT_W
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic enable,
   input  wire logic senseIn,
   output logic      active
);

   localparam logic [CNT_W-1:0] MIN_PER = CNT_W'(plsc_pkg::LPS_MIN_PERIOD_CYC);
   localparam logic [CNT_W-1:0] MAX_PER = CNT_W'(plsc_pkg::LPS_MAX_PERIOD_CYC);

   typedef struct packed {
      logic             prev;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] stable;
      logic             active;
   } plsc_lps_type;

   plsc_lps_type st_ff;
   plsc_lps_type nxt_st;

   // Period counts cycles from rise to rise; stable counts since any edge
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = senseIn;
      if (!enable) begin
         nxt_st.period = '0;
         nxt_st.stable = '0;
         nxt_st.active = 1'b0;
      end else begin
         if (st_ff.period != MAX_PER) begin
            nxt_st.period = st_ff.period + 1'b1;
         end
         if (st_ff.stable != MAX_PER) begin
            nxt_st.stable = st_ff.stable + 1'b1;
         end
         if (senseIn != st_ff.prev) begin
            nxt_st.stable = '0;
         end
         if (senseIn && !st_ff.prev) begin
            // Period in cycles is count plus one
            nxt_st.active = (st_ff.period >= MIN_PER - 1'b1) &&
                            (st_ff.period <= MAX_PER - 1'b1);
            nxt_st.period = '0;
         end else if (st_ff.stable == MAX_PER) begin
            // No edge for a full slow period: a tied level decides
            nxt_st.active = senseIn;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign active = st_ff.active;

endmodule
`default_nettype wire

//--- dv/plsc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the link-side control block
module plsc_top_chk #(
   parameter int LINK_CLK_HZ = plsc_pkg::LINK_CLK_HZ
) (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        linkPowerSense,
   input wire logic [2:0]  powerClassInputs,
   input wire logic        powerDownInput,
   input wire logic        resetPin_n,
   input wire logic [2:0]  portActive,
   input wire logic        linkOnMsg,
   input wire logic        managerCapLinkonOe,
   input wire logic        cableInactiveFlag,
   input wire logic        linkSideClock,
   input wire logic        linkIfEnable,
   input wire logic [2:0]  busResetReq,
   input wire logic [0:31] selfIdWord
);
   // High time of the link clock; one cycle of slack for phase rounding
   localparam int HALF   = plsc_pkg::SYS_CLK_HZ / LINK_CLK_HZ / 2;
   localparam int HI_MIN = (HALF > 1) ? HALF - 1 : 1;
   localparam int HI_MAX = HALF + 1;
   logic [8:0] lpsQuiet_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // Cycles since the power sense pin last moved, saturating
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         lpsQuiet_ff <= 9'h000;
      end else if ($changed(linkPowerSense)) begin
         lpsQuiet_ff <= 9'h000;
      end else if (lpsQuiet_ff != 9'h1ff) begin
         lpsQuiet_ff <= lpsQuiet_ff + 9'h001;
      end
   end

   apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("APB answer not a single cycle after setup");
   lps_accept_a: assert property (
      $rose(linkIfEnable) |-> linkPowerSense || lpsQuiet_ff < 9'h104)
      else $error("link interface enabled without power sense");
   lps_idle_a: assert property (
      lpsQuiet_ff > 9'h104 && !linkPowerSense |-> !linkIfEnable)
      else $error("link interface on with power sense idle low");
   selfid_copy_a: assert property (
      ($stable(powerClassInputs) && !powerDownInput && resetPin_n)[*5]
      |-> selfIdWord == {21'h0, powerClassInputs, 8'h00})
      else $error("self-id power class bits wrong");
   pd_quiet_a: assert property (
      powerDownInput[*6] |-> !linkSideClock && !linkIfEnable && !managerCapLinkonOe)
      else $error("activity during power-down");
   bus_reset_a: assert property (
      (!resetPin_n && !powerDownInput && $stable(portActive))[*5]
      |-> busResetReq == portActive && !linkIfEnable)
      else $error("bus reset not raised on active ports");
   link_clock_a: assert property (@(posedge sys_clk) disable iff (reset || powerDownInput)
      $rose(linkSideClock) |-> ##[HI_MIN:HI_MAX] $fell(linkSideClock))
      else $error("link clock high time wrong");
   cna_flag_a: assert property (
      $stable(portActive)[*4] |-> cableInactiveFlag == (portActive == 3'h0))
      else $error("cable inactive flag wrong");
   link_on_a: assert property (
      (resetPin_n && !powerDownInput)[*3] ##0 linkOnMsg |-> ##2 managerCapLinkonOe)
      else $error("link-on drive late");

   cover property ($rose(linkIfEnable));
   cover property ($rose(managerCapLinkonOe));
   cover property (busResetReq != 3'h0);
endmodule

bind plsc_top plsc_top_chk #(.LINK_CLK_HZ(LINK_CLK_HZ)) i_plsc_top_chk (
   .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
   .linkPowerSense(linkPowerSense), .powerClassInputs(powerClassInputs),
   .powerDownInput(powerDownInput), .resetPin_n(resetPin_n), .portActive(portActive),
   .linkOnMsg(linkOnMsg), .managerCapLinkonOe(managerCapLinkonOe),
   .cableInactiveFlag(cableInactiveFlag), .linkSideClock(linkSideClock),
   .linkIfEnable(linkIfEnable), .busResetReq(busResetReq), .selfIdWord(selfIdWord)
);
`default_nettype wire

//--- dv/plsc_llc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Link controller stand-in: power pulses and link requests
module plsc_llc_model #(
   parameter int HALF_PER = 25
) (
   input  wire logic sys_clk,
   input  wire logic linkSideClock,
   input  wire logic powered,
   input  wire logic reqGo,
   output logic      linkPowerSense,
   output logic      linkRequest
);
   int pulseCnt = 0;

   initial linkPowerSense = 1'b0;
   initial linkRequest = 1'b0;

   // Pulse train while powered; an unpowered link lets the pin fall low
   always @(posedge sys_clk) begin
      pulseCnt = (pulseCnt + 1) % HALF_PER;
      if (!powered) begin
         linkPowerSense <= 1'b0;
      end else if (pulseCnt == 0) begin
         linkPowerSense <= !linkPowerSense;
      end
   end

   // Requests launched on the device's link clock, as a real link would
   always @(posedge linkSideClock) begin
      linkRequest <= reqGo;
   end
endmodule
`default_nettype wire

//--- dv/tb_phy_link_side_control.sv
`timescale 1ns/1ps
`default_nettype none
// Reset and APB checks first, then the table of pin cases, then hand-written corner cases
module tb_phy_link_side_control;
   typedef struct packed {
      logic [2:0] pa;
      logic [2:0] pc;
      logic       cable_inactive_flag;
   } plsc_row_type;
   logic         sys_clk = 1'b0;
   logic         reset = 1'b1;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [2:0]   powerClassInputs = 3'h0;
   logic [2:0]   portActive = 3'h0;
   logic         powerDownInput = 1'b0;
   logic         resetPin_n = 1'b1;
   logic         factoryTestSel1 = 1'b1;
   logic         factoryTestSel2 = 1'b1;
   logic         linkOnMsg = 1'b0;
   logic         powered = 1'b0;
   logic         reqGo = 1'b0;
   logic         mgrStrap = 1'b1;
   logic [31:0]  prdata, rd;
   logic         pready, pslverr, er, linkPowerSense, linkRequest;
   logic         managerCapLinkonIn, managerCapLinkonOut, managerCapLinkonOe;
   logic         cableInactiveFlag, linkSideClock, linkIfEnable, linkReqStrobe;
   logic [2:0]   busResetReq;
   logic [0:31]  selfIdWord;
   int           nErrors = 0;
   int           checkCount = 0;
   int           cycles = 0;
   int           clkHi = 0;
   int           toneHi = 0;
   int           strobes = 0;
   int           brHits = 0;
   plsc_row_type rows [8] = '{'{3'h0, 3'h0, 1'b1}, '{3'h1, 3'h1, 1'b0}, '{3'h2, 3'h2, 1'b0},
      '{3'h4, 3'h3, 1'b0}, '{3'h0, 3'h4, 1'b1}, '{3'h7, 3'h5, 1'b0}, '{3'h3, 3'h6, 1'b0},
      '{3'h0, 3'h7, 1'b1}};

   // Shared pin: tone while the device drives it, else the pulled strap
   assign managerCapLinkonIn = managerCapLinkonOe ? managerCapLinkonOut : mgrStrap;

   always #10 sys_clk = ~sys_clk;

   // Slow link clock so the wave is clean at 50 MHz sampling
   plsc_top #(.LINK_CLK_HZ(5_000_000), .LINKON_HZ(2_500_000)) i_plsc_top (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .linkPowerSense(linkPowerSense), .linkRequest(linkRequest),
      .powerClassInputs(powerClassInputs), .powerDownInput(powerDownInput),
      .resetPin_n(resetPin_n), .factoryTestSel1(factoryTestSel1),
      .factoryTestSel2(factoryTestSel2), .managerCapLinkonIn(managerCapLinkonIn),
      .managerCapLinkonOut(managerCapLinkonOut), .managerCapLinkonOe(managerCapLinkonOe),
      .cableInactiveFlag(cableInactiveFlag), .linkSideClock(linkSideClock),
      .portActive(portActive), .linkOnMsg(linkOnMsg), .linkIfEnable(linkIfEnable),
      .linkReqStrobe(linkReqStrobe), .busResetReq(busResetReq), .selfIdWord(selfIdWord));

   plsc_llc_model i_plsc_llc_model (.sys_clk(sys_clk), .linkSideClock(linkSideClock),
      .powered(powered), .reqGo(reqGo), .linkPowerSense(linkPowerSense),
      .linkRequest(linkRequest));

   // Cycle limit and tallies; only the clock and tone tallies are checked with slack
   always @(posedge sys_clk) begin
      cycles++;
      strobes += int'(linkReqStrobe === 1'b1);
      brHits += int'(busResetReq === 3'h2);
      clkHi += int'(linkSideClock === 1'b1);
      toneHi += int'(managerCapLinkonIn === 1'b1);
      if (cycles == 5000) begin
         nErrors++;
         finish_test();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // One APB transfer; waits on pready, the cycle limit cuts a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic req_pulse();
      // Longer than one link clock period, so one link edge sees each level
      reqGo <= 1'b1;
      cyc(15);
      reqGo <= 1'b0;
      cyc(15);
   endtask

   task automatic finish_test();
      if (nErrors == 0 && checkCount > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      cyc(2);
      check("clock in reset", 32'h0, 32'(linkSideClock));
      cyc(2);
      reset <= 1'b0;
      apb(1'b0, plsc_pkg::CTRL_OFS, 32'h0);
      check("ctrl reset", plsc_pkg::CTRL_RESET, rd);
      apb(1'b1, 8'h40, 32'hffff_ffff);
      check("unmapped error", 32'h1, 32'(er));
      // Table of port and strap patterns
      foreach (rows[i]) begin
         portActive <= rows[i].pa;
         powerClassInputs <= rows[i].pc;
         cyc(5);
         check("cable inactive", 32'(rows[i].cable_inactive_flag), 32'(cableInactiveFlag));
         check("self id", {21'h0, rows[i].pc, 8'h00}, selfIdWord);
         apb(1'b0, plsc_pkg::STATUS_OFS, 32'h0);
         check("status ports", 32'(rows[i].pa), 32'(rd[10:8]));
      end
      apb(1'b0, plsc_pkg::STRAP_OFS, 32'h0);
      check("strap", 32'h17, rd);
      // Link powered: two requests, then refused while forced off
      powered <= 1'b1;
      cyc(300);
      check("link if on", 32'h1, 32'(linkIfEnable));
      req_pulse();
      req_pulse();
      apb(1'b1, plsc_pkg::CTRL_OFS, 32'h2);
      cyc(3);
      req_pulse();
      apb(1'b0, plsc_pkg::REQCNT_OFS, 32'h0);
      check("requests", 32'h2, rd);
      check("strobes", 32'h2, 32'(strobes));
      apb(1'b1, plsc_pkg::CTRL_OFS, 32'h0);
      powered <= 1'b0;
      cyc(300);
      check("link if off", 32'h0, 32'(linkIfEnable));
      // Link-on tone replaces the strap level on the shared pin
      linkOnMsg <= 1'b1;
      @(posedge sys_clk);
      linkOnMsg <= 1'b0;
      cyc(3);
      check("link-on drive", 32'h1, 32'(managerCapLinkonOe));
      toneHi = 0;
      cyc(40);
      check("link-on tone", 32'h1, 32'(toneHi > 10 && toneHi < 30));
      // Reset pin: bus reset on active ports, clock keeps running
      portActive <= 3'h5;
      resetPin_n <= 1'b0;
      clkHi = 0;
      cyc(40);
      check("bus reset", 32'h5, 32'(busResetReq));
      check("link-on cleared", 32'h0, 32'(managerCapLinkonOe));
      check("clock runs", 32'h1, 32'(clkHi > 10 && clkHi < 30));
      apb(1'b0, plsc_pkg::REQCNT_OFS, 32'h0);
      check("count cleared", 32'h0, rd);
      resetPin_n <= 1'b1;
      // Power-down: clock stops, cable monitor still tracks ports
      portActive <= 3'h0;
      powerDownInput <= 1'b1;
      cyc(6);
      clkHi = 0;
      cyc(40);
      check("clock stopped", 32'h0, 32'(clkHi));
      check("cna in pd", 32'h1, 32'(cableInactiveFlag));
      portActive <= 3'h2;
      cyc(5);
      check("cna in pd", 32'h0, 32'(cableInactiveFlag));
      powerDownInput <= 1'b0;
      factoryTestSel2 <= 1'b0;
      cyc(5);
      apb(1'b0, plsc_pkg::STATUS_OFS, 32'h0);
      check("test selects", 32'h0, 32'(rd[plsc_pkg::ST_TESTOK_BIT]));
      factoryTestSel2 <= 1'b1;
      cyc(5);
      apb(1'b0, plsc_pkg::STATUS_OFS, 32'h0);
      check("test selects", 32'h1, 32'(rd[plsc_pkg::ST_TESTOK_BIT]));
      // Software bus reset: one pulse on the active port
      brHits = 0;
      apb(1'b1, plsc_pkg::CTRL_OFS, 32'h1);
      cyc(3);
      check("software bus reset", 32'h1, 32'(brHits));
      finish_test();
   end
endmodule
`default_nettype wire
